// ---- shared/zbt_params.svh ----
// constants for the zone bus timing configuration block
`ifndef ZBT_PARAMS_SVH
`define ZBT_PARAMS_SVH
`define ZBT_ADDR_IO 4'h1
`define ZBT_ADDR_Z0 4'h2
`define ZBT_ADDR_Z1 4'h3
`define ZBT_ADDR_STAT 4'h4
`define ZBT_RESET_CFG 16'h069F
`define ZBT_WAIT_LO 0
`define ZBT_WAIT_HI 2
`define ZBT_HOLD_LO 3
`define ZBT_HOLD_HI 4
`define ZBT_RBE_BIT 5
`define ZBT_WBR_BIT 6
`define ZBT_BW_BIT 7
`define ZBT_TRAILING_IDLE_BIT_BIT 9
`define ZBT_LEADING_IDLE_BIT_BIT 10
`define ZBT_FRE_BIT 11
`define ZBT_WRITABLE 16'h0EFF
`define ZBT_RESERVED 16'hF100
`define ZBT_ZONE_IO 2'h0
`define ZBT_ZONE_Z0 2'h1
`define ZBT_ZONE_Z1 2'h2
`define ZBT_ZONE_NONE 2'h3
`endif

// ---- shared/zbt_pkg.sv ----
// types for the zone bus timing configuration block
package zbt_pkg;
	typedef enum logic [2:0] {
		ZBT_IDLE = 3'h0,
		ZBT_PRE = 3'h1,
		ZBT_WAIT = 3'h2,
		ZBT_BURST = 3'h3,
		ZBT_HOLD = 3'h4,
		ZBT_POST = 3'h5
	} zbt_state_type;
endpackage

// ---- logic/zbt_cfg_reg.sv ----
// one 16-bit zone configuration register
`timescale 1ns/1ns
`include "zbt_params.svh"
module zbt_cfg_reg #(
	parameter logic [15:0] RESET_VALUE = `ZBT_RESET_CFG
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// write side
	input wire logic wr_i,
	input wire logic [15:0] data_i,
	// stored value
	output logic [15:0] value_o
);
	logic [15:0] next_value;

	// reserved bits never store, so they read back as zero
	always_comb begin
		next_value = value_o;
		if (wr_i) begin
			next_value = data_i & `ZBT_WRITABLE;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			value_o <= RESET_VALUE;
		end else begin
			value_o <= next_value;
		end
	end
endmodule // zbt_cfg_reg

// ---- logic/zbt_timing.sv ----
// zone timing configuration registers and access cycle sequencer
//
// Design decisions made here: the address-and-strobe port and the register addresses.
`timescale 1ns/1ns
`include "zbt_params.svh"
module zbt_timing
	import zbt_pkg::*;
(
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// register port
	input wire logic [3:0] addr_i,
	input wire logic [15:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [15:0] rdata_o,
	// access request from the core bus
	input wire logic req_i,
	input wire logic [1:0] req_zone_i,
	input wire logic req_read_i,
	input wire logic req_wide_i,
	// access sequencing toward the zones
	output logic busy_o,
	output logic done_o,
	output logic zone1_select_output,
	output logic bus_wide_o,
	output logic idle_o
);
	import zbt_pkg::*;

	logic [15:0] io_zone_config;
	logic [15:0] zone0_config;
	logic [15:0] zone1_config;
	zbt_state_type state, next_state;
	logic [2:0] count, next_count;
	logic [1:0] zone, next_zone;
	logic [1:0] last_zone, next_last_zone;
	logic rd_op, next_rd_op;
	logic burst, next_burst;
	logic post_pend, next_post_pend;
	logic [15:0] next_rdata;
	logic next_busy, next_done, next_zone1_select_output, next_wide, next_idle;
	logic [15:0] cfg;
	logic [15:0] req_cfg;
	logic [2:0] eff_wait;
	logic [1:0] eff_hold;
	logic fast;

	// refuse a field map that would store reserved bits
	if ((`ZBT_WRITABLE & `ZBT_RESERVED) != 16'h0000) begin : g_bad_mask
		$error("writable mask reaches reserved bits");
	end
	// a reset value outside the mask could never be written back
	if ((`ZBT_RESET_CFG & ~`ZBT_WRITABLE) != 16'h0000) begin : g_bad_reset
		$error("reset value sets unwritable bits");
	end

	// three configuration registers; the io one shares layout
	zbt_cfg_reg #(.RESET_VALUE(`ZBT_RESET_CFG)) u_io (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.wr_i(wr_i && addr_i == `ZBT_ADDR_IO),
		.data_i(wdata_i),
		.value_o(io_zone_config)
	);
	zbt_cfg_reg #(.RESET_VALUE(`ZBT_RESET_CFG)) u_z0 (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.wr_i(wr_i && addr_i == `ZBT_ADDR_Z0),
		.data_i(wdata_i),
		.value_o(zone0_config)
	);
	zbt_cfg_reg #(.RESET_VALUE(`ZBT_RESET_CFG)) u_z1 (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.wr_i(wr_i && addr_i == `ZBT_ADDR_Z1),
		.data_i(wdata_i),
		.value_o(zone1_config)
	);

	// read decode; unmapped addresses answer zero
	always_comb begin
		next_rdata = 16'h0000;
		if (rd_i && addr_i == `ZBT_ADDR_IO) begin
			next_rdata = io_zone_config;
		end else if (rd_i && addr_i == `ZBT_ADDR_Z0) begin
			next_rdata = zone0_config;
		end else if (rd_i && addr_i == `ZBT_ADDR_Z1) begin
			next_rdata = zone1_config;
		end else if (rd_i && addr_i == `ZBT_ADDR_STAT) begin
			next_rdata = {8'h00, busy_o, 2'h0, state, zone};
		end
	end

	// configuration of the zone in service picks wait, hold, width
	always_comb begin
		case (zone)
			`ZBT_ZONE_IO: cfg = io_zone_config;
			`ZBT_ZONE_Z0: cfg = zone0_config;
			default: cfg = zone1_config;
		endcase
		case (req_zone_i)
			`ZBT_ZONE_IO: req_cfg = io_zone_config;
			`ZBT_ZONE_Z0: req_cfg = zone0_config;
			default: req_cfg = zone1_config;
		endcase
		// fast read overrides wait and hold on reads only
		fast = rd_op && cfg[`ZBT_FRE_BIT];
		eff_wait = fast ? 3'h0 : cfg[`ZBT_WAIT_HI:`ZBT_WAIT_LO];
		eff_hold = fast ? 2'h0 : cfg[`ZBT_HOLD_HI:`ZBT_HOLD_LO];
	end

	// access sequencer: pre idle, address/wait, burst, hold, post idle
	always_comb begin
		next_state = state;
		next_count = count;
		next_zone = zone;
		next_last_zone = last_zone;
		next_rd_op = rd_op;
		next_burst = burst;
		next_post_pend = post_pend;
		next_done = 1'b0;
		next_idle = 1'b0;
		case (state)
			ZBT_IDLE: begin
				if (req_i) begin
					next_zone = req_zone_i;
					next_rd_op = req_read_i;
					// zone 0 flash never bursts
					next_burst = req_read_i && req_wide_i &&
						req_zone_i != `ZBT_ZONE_Z0 &&
						!req_cfg[`ZBT_BW_BIT] &&
						req_cfg[`ZBT_RBE_BIT] &&
						!req_cfg[`ZBT_FRE_BIT];
					// a pending trailing idle goes first on a zone change
					if (post_pend && req_zone_i != last_zone) begin
						next_state = ZBT_POST;
						next_idle = 1'b1;
					end else if (req_cfg[`ZBT_LEADING_IDLE_BIT_BIT] &&
						req_zone_i != last_zone) begin
						next_state = ZBT_PRE;
						next_idle = 1'b1;
					end else begin
						next_state = ZBT_WAIT;
						next_count = 3'h0;
					end
				end
			end
			ZBT_POST: begin
				next_post_pend = 1'b0;
				// the request lines are released by now, so the zone
				// taken at the request edge picks the config here
				if (cfg[`ZBT_LEADING_IDLE_BIT_BIT] && zone != last_zone) begin
					next_state = ZBT_PRE;
					next_idle = 1'b1;
				end else begin
					next_state = ZBT_WAIT;
					next_count = 3'h0;
				end
			end
			ZBT_PRE: begin
				next_state = ZBT_WAIT;
				next_count = 3'h0;
			end
			ZBT_WAIT: begin
				// fast read ends here in one cycle; normal adds a second
				// lowering the wait field mid-access lets the count wrap once
				if (count != eff_wait) begin
					next_count = count + 3'h1;
				end else if (fast) begin
					next_state = ZBT_IDLE;
					next_done = 1'b1;
				end else if (burst && cfg[`ZBT_WBR_BIT]) begin
					next_state = ZBT_BURST;
				end else begin
					next_state = ZBT_HOLD;
					next_count = 3'h0;
				end
			end
			ZBT_BURST: begin
				next_state = ZBT_HOLD;
				next_count = 3'h0;
			end
			ZBT_HOLD: begin
				if (count[1:0] == eff_hold) begin
					next_state = ZBT_IDLE;
					next_done = 1'b1;
				end else begin
					next_count = count + 3'h1;
				end
			end
			default: begin
				next_state = ZBT_IDLE;
			end
		endcase
		if (next_done) begin
			next_last_zone = zone;
			next_post_pend = cfg[`ZBT_TRAILING_IDLE_BIT_BIT];
		end
		next_busy = next_state != ZBT_IDLE;
		next_zone1_select_output = next_state != ZBT_IDLE && next_state != ZBT_PRE &&
			next_state != ZBT_POST && next_zone == `ZBT_ZONE_Z1;
		// width of the zone in service; zone 0 is kept wide by software
		next_wide = next_zone == `ZBT_ZONE_IO ? io_zone_config[`ZBT_BW_BIT] :
			next_zone == `ZBT_ZONE_Z0 ? zone0_config[`ZBT_BW_BIT] :
			zone1_config[`ZBT_BW_BIT];
	end

	// register all state and outputs
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			state <= ZBT_IDLE;
			count <= 3'h0;
			zone <= `ZBT_ZONE_IO;
			last_zone <= `ZBT_ZONE_NONE;
			rd_op <= 1'b0;
			burst <= 1'b0;
			post_pend <= 1'b0;
			rdata_o <= 16'h0000;
			busy_o <= 1'b0;
			done_o <= 1'b0;
			zone1_select_output <= 1'b0;
			bus_wide_o <= 1'b1;
			idle_o <= 1'b0;
		end else begin
			state <= next_state;
			count <= next_count;
			zone <= next_zone;
			last_zone <= next_last_zone;
			rd_op <= next_rd_op;
			burst <= next_burst;
			post_pend <= next_post_pend;
			rdata_o <= next_rdata;
			busy_o <= next_busy;
			done_o <= next_done;
			zone1_select_output <= next_zone1_select_output;
			bus_wide_o <= next_wide;
			idle_o <= next_idle;
		end
	end

	// checks
	sequence s_start;
		state == ZBT_IDLE && req_i;
	endsequence
	// last wait cycle of a normal access that owes a burst wait
	sequence s_burst_due;
		state == ZBT_WAIT && count == eff_wait && !fast &&
			burst && cfg[`ZBT_WBR_BIT];
	endsequence
	// extra burst wait cycle, then the hold phase
	sequence s_burst_tail;
		state == ZBT_BURST ##1 state == ZBT_HOLD;
	endsequence
	// last hold cycle of an access
	sequence s_hold_end;
		state == ZBT_HOLD && count[1:0] == eff_hold;
	endsequence
	AST_Z0_RESET: assert property (@(posedge clk_i)
		$fell(rst_i) |-> zone0_config == `ZBT_RESET_CFG)
		else $error("zone 0 reset value wrong");
	AST_IO_RESET: assert property (@(posedge clk_i)
		$fell(rst_i) |-> io_zone_config == `ZBT_RESET_CFG)
		else $error("io reset value wrong");
	AST_RSVD: assert property (@(posedge clk_i) disable iff (rst_i)
		zone1_config[15:12] == 4'h0 && zone0_config[8] == 1'b0)
		else $error("reserved bit stored");
	AST_Z1_WRITE: assert property (@(posedge clk_i) disable iff (rst_i)
		wr_i && addr_i == `ZBT_ADDR_Z1 |=>
		zone1_config == ($past(wdata_i) & `ZBT_WRITABLE))
		else $error("zone 1 write lost");
	AST_READBACK: assert property (@(posedge clk_i) disable iff (rst_i)
		rd_i && addr_i == `ZBT_ADDR_Z0 |=> rdata_o == $past(zone0_config))
		else $error("zone 0 readback wrong");
	AST_FAST: assert property (@(posedge clk_i) disable iff (rst_i)
		state == ZBT_WAIT && fast |-> next_done)
		else $error("fast read took more than one cycle");
	AST_NORMAL: assert property (@(posedge clk_i) disable iff (rst_i)
		state == ZBT_WAIT && rd_op && !fast |=> !done_o)
		else $error("normal read under two cycles");
	AST_WAIT_MAX: assert property (@(posedge clk_i) disable iff (rst_i)
		s_start |-> ##[1:20] state == ZBT_IDLE)
		else $error("access ran too long");
	AST_PRE: assert property (@(posedge clk_i) disable iff (rst_i)
		state == ZBT_PRE |-> idle_o ##1 state == ZBT_WAIT)
		else $error("leading idle misplaced");
	AST_BURST_Z0: assert property (@(posedge clk_i) disable iff (rst_i)
		state != ZBT_IDLE && zone == `ZBT_ZONE_Z0 |-> !burst)
		else $error("zone 0 burst");
	// phase by phase timing of one access, then zone 0 and io write checks
	AST_STEP: assert property (@(posedge clk_i) disable iff (rst_i)
		state == ZBT_WAIT && count != eff_wait |=>
		state == ZBT_WAIT && count == $past(count) + 3'h1)
		else $error("wait cycle skipped");
	AST_HOLD_END: assert property (@(posedge clk_i) disable iff (rst_i)
		s_hold_end |=> done_o && !busy_o)
		else $error("hold phase did not end the access");
	AST_BURST_WT: assert property (@(posedge clk_i) disable iff (rst_i)
		s_burst_due |=> s_burst_tail)
		else $error("burst wait cycle missing");
	AST_NO_BURST: assert property (@(posedge clk_i) disable iff (rst_i)
		!burst |-> state != ZBT_BURST)
		else $error("burst cycle without burst access");
	AST_POST: assert property (@(posedge clk_i) disable iff (rst_i)
		state == ZBT_POST |-> idle_o && zone != last_zone)
		else $error("trailing idle misplaced");
	AST_PRE_ZONE: assert property (@(posedge clk_i) disable iff (rst_i)
		state == ZBT_PRE |-> zone != last_zone && cfg[`ZBT_LEADING_IDLE_BIT_BIT])
		else $error("leading idle without zone change");
	AST_ZONE1_SELECT_OUTPUT: assert property (@(posedge clk_i) disable iff (rst_i)
		zone1_select_output == (zone == `ZBT_ZONE_Z1 &&
		(state == ZBT_WAIT || state == ZBT_BURST || state == ZBT_HOLD)))
		else $error("zone 1 select wrong");
	AST_WIDE: assert property (@(posedge clk_i) disable iff (rst_i)
		busy_o && !$past(wr_i) |-> bus_wide_o == cfg[`ZBT_BW_BIT])
		else $error("bus width does not follow zone");
	AST_DONE_ONE: assert property (@(posedge clk_i) disable iff (rst_i)
		done_o |-> !busy_o ##1 !done_o)
		else $error("done longer than one cycle");
	AST_NORM_TWO: assert property (@(posedge clk_i) disable iff (rst_i)
		state == ZBT_WAIT && rd_op && !fast |=> state != ZBT_IDLE)
		else $error("normal read ended in one cycle");
	AST_Z0_WRITE: assert property (@(posedge clk_i) disable iff (rst_i)
		wr_i && addr_i == `ZBT_ADDR_Z0 |=>
		zone0_config == ($past(wdata_i) & `ZBT_WRITABLE))
		else $error("zone 0 write lost");
	AST_IO_WRITE: assert property (@(posedge clk_i) disable iff (rst_i)
		wr_i && addr_i == `ZBT_ADDR_IO |=>
		io_zone_config == ($past(wdata_i) & `ZBT_WRITABLE))
		else $error("io write lost");
endmodule // zbt_timing

// ---- bench/zbt_core_model.sv ----
// core bus requester that times zone accesses
`timescale 1ns/1ns
module zbt_core_model (
	// clock
	input wire logic clk_i,
	// access request toward the block
	output logic req_o,
	output logic [1:0] zone_o,
	output logic read_o,
	output logic wide_o,
	// access progress from the block
	input wire logic busy_i,
	input wire logic done_i,
	input wire logic sel_i,
	input wire logic wide_i,
	input wire logic idle_i
);
	logic seen_sel;
	logic seen_wide;
	int seen_idle;
	// idle request lines at time zero
	initial begin
		req_o = 1'b0;
		zone_o = 2'h3;
		read_o = 1'b0;
		wide_o = 1'b0;
	end
	// one request, then count edges up to done; -1 flags a hang
	task automatic access(input logic [1:0] z, input logic rd,
		input logic wd, output int n);
		@(posedge clk_i);
		req_o <= 1'b1;
		zone_o <= z;
		read_o <= rd;
		wide_o <= wd;
		seen_sel = 1'b0;
		@(posedge clk_i);
		req_o <= 1'b0;
		// released qualifiers show garbage so nothing leans on them
		zone_o <= ~z;
		read_o <= ~rd;
		wide_o <= ~wd;
		n = -1;
		// an idle cycle shows right after the taking edge
		#1;
		seen_idle = (idle_i === 1'b1) ? 1 : 0;
		for (int i = 1; i < 64; i++) begin
			@(posedge clk_i);
			#1;
			if (idle_i === 1'b1) begin
				seen_idle++;
			end
			if (busy_i === 1'b1) begin
				seen_sel = seen_sel | sel_i;
				seen_wide = wide_i;
			end
			if (done_i === 1'b1) begin
				// the edge that takes the request counts as cycle one
				n = i + 1;
				break;
			end
		end
	endtask
endmodule // zbt_core_model

// ---- bench/zbt_timing_bench.sv ----
// self-checking bench for the zone timing block
`timescale 1ns/1ns
`include "zbt_params.svh"
module zbt_timing_bench;
	import zbt_pkg::*;
	logic clk_i, rst_i, wr_i, rd_i, req_i, req_read_i, req_wide_i;
	logic busy_o, done_o, zone1_select_output, bus_wide_o, idle_o;
	logic [3:0] addr_i;
	logic [15:0] wdata_i, rdata_o, n, d;
	logic [1:0] req_zone_i;
	int fails = 0;
	int cmp_count = 0;
	zbt_timing dut_u (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
		.req_i(req_i), .req_zone_i(req_zone_i), .req_read_i(req_read_i),
		.req_wide_i(req_wide_i), .busy_o(busy_o), .done_o(done_o),
		.zone1_select_output(zone1_select_output),
		.bus_wide_o(bus_wide_o), .idle_o(idle_o));
	zbt_core_model model_u (.clk_i(clk_i), .req_o(req_i),
		.zone_o(req_zone_i), .read_o(req_read_i), .wide_o(req_wide_i),
		.busy_i(busy_o), .done_i(done_o), .sel_i(zone1_select_output),
		.wide_i(bus_wide_o), .idle_i(idle_o));
	// free-running 100 MHz clock
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			fails++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	task automatic complete_run();
		$display("compares %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	// register port cycles: one-cycle strobes, read data one cycle later
	task automatic wr(input logic [3:0] a, input logic [15:0] v);
		@(posedge clk_i);
		wr_i <= 1'b1;
		addr_i <= a;
		wdata_i <= v;
		@(posedge clk_i);
		wr_i <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, output logic [15:0] v);
		@(posedge clk_i);
		rd_i <= 1'b1;
		addr_i <= a;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1;
		v = rdata_o;
	endtask
	// program one register, then time one access
	task automatic run(input logic [3:0] a, input logic [15:0] c,
		input logic [1:0] z, input logic r, input logic wd,
		output logic [15:0] cyc);
		int k;
		wr(a, c);
		model_u.access(z, r, wd, k);
		cyc = 16'(k);
		if (k < 0) begin
			fails++;
			$display("unexpected at %0t: access hung", $time);
			complete_run();
		end
	endtask
	task automatic t_regs();
		rd(`ZBT_ADDR_IO, d);
		check(d, 16'h069F);
		rd(`ZBT_ADDR_Z0, d);
		check(d, 16'h069F);
		rd(`ZBT_ADDR_Z1, d);
		check(d, 16'h069F);
		wr(`ZBT_ADDR_Z0, 16'hFFFF);
		rd(`ZBT_ADDR_Z0, d);
		check(d, 16'h0EFF);
		wr(4'h0, 16'hFFFF);
		rd(4'h0, d);
		check(d, 16'h0000);
		$display("test registers done");
	endtask
	task automatic t_wait_hold();
		int h;
		wr(`ZBT_ADDR_Z1, 16'h0080);
		for (int w = 0; w < 8; w++) begin
			h = w % 4;
			run(`ZBT_ADDR_IO, 16'(w + h * 8 + 128), `ZBT_ZONE_IO, 1'b1, 1'b1, n);
			check(n, 16'(3 + w + h));
			// width stays 16-bit on the flash zone
			run(`ZBT_ADDR_Z0, 16'(w + h * 8 + 128), `ZBT_ZONE_Z0, 1'b0, 1'b1, n);
			check(n, 16'(3 + w + h));
		end
		// status shows the flash zone last served, sequencer at rest
		rd(`ZBT_ADDR_STAT, d);
		check(d, 16'h0001);
		$display("test wait and hold done");
	endtask
	task automatic t_fast_width();
		run(`ZBT_ADDR_Z0, 16'h089F, `ZBT_ZONE_Z0, 1'b1, 1'b1, n);
		check(n, 16'h0002);
		run(`ZBT_ADDR_IO, 16'h0000, `ZBT_ZONE_IO, 1'b1, 1'b1, n);
		check(16'(model_u.seen_wide), 16'h0000);
		check(16'(model_u.seen_sel), 16'h0000);
		run(`ZBT_ADDR_IO, 16'h0080, `ZBT_ZONE_IO, 1'b1, 1'b1, n);
		check(16'(model_u.seen_wide), 16'h0001);
		run(`ZBT_ADDR_Z1, 16'h0080, `ZBT_ZONE_Z1, 1'b1, 1'b1, n);
		check(16'(model_u.seen_sel), 16'h0001);
		$display("test fast read and width done");
	endtask
	task automatic t_burst();
		run(`ZBT_ADDR_Z1, 16'h0060, `ZBT_ZONE_Z1, 1'b1, 1'b1, n);
		check(n, 16'h0004);
		run(`ZBT_ADDR_Z1, 16'h0060, `ZBT_ZONE_Z1, 1'b1, 1'b0, n);
		check(n, 16'h0003);
		run(`ZBT_ADDR_Z1, 16'h00E0, `ZBT_ZONE_Z1, 1'b1, 1'b1, n);
		check(n, 16'h0003);
		run(`ZBT_ADDR_Z1, 16'h0040, `ZBT_ZONE_Z1, 1'b1, 1'b1, n);
		check(n, 16'h0003);
		run(`ZBT_ADDR_Z1, 16'h0860, `ZBT_ZONE_Z1, 1'b1, 1'b1, n);
		check(n, 16'h0002);
		$display("test burst done");
	endtask
	task automatic t_idle();
		int k;
		wr(`ZBT_ADDR_Z1, 16'h0080);
		run(`ZBT_ADDR_IO, 16'h0280, `ZBT_ZONE_IO, 1'b1, 1'b1, n);
		check(n, 16'h0003);
		run(`ZBT_ADDR_IO, 16'h0280, `ZBT_ZONE_IO, 1'b1, 1'b1, n);
		check(n, 16'h0003);
		run(`ZBT_ADDR_IO, 16'h0080, `ZBT_ZONE_Z1, 1'b1, 1'b1, n);
		check(n, 16'h0004);
		check(16'(model_u.seen_idle), 16'h0001);
		run(`ZBT_ADDR_Z1, 16'h0480, `ZBT_ZONE_IO, 1'b1, 1'b1, n);
		check(n, 16'h0003);
		model_u.access(`ZBT_ZONE_Z1, 1'b1, 1'b1, k);
		check(16'(k), 16'h0004);
		if (k < 0) begin
			complete_run();
		end
		check(16'(model_u.seen_idle), 16'h0001);
		run(`ZBT_ADDR_IO, 16'h0080, `ZBT_ZONE_Z1, 1'b1, 1'b1, n);
		check(n, 16'h0003);
		check(16'(model_u.seen_idle), 16'h0000);
		$display("test idle cycles done");
	endtask
	// reset, then the scenarios in turn
	initial begin
		rst_i = 1'b1;
		addr_i = 4'h0;
		wdata_i = 16'h0000;
		wr_i = 1'b0;
		rd_i = 1'b0;
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		t_regs();
		t_wait_hold();
		t_fast_width();
		t_burst();
		t_idle();
		complete_run();
	end
endmodule // zbt_timing_bench
